// ===== logic/adc_config_alert_control.sv
// configuration, bus hold-off and alert pin control of a monitoring ADC
// assumes an AXI4-Lite master on the system clock; serial pins async
//
// Function
// - D14 low: sampling waits while bus active
// - D13 low: bit trials wait while bus active
// - D14, D13, D3 read zero after reset
// - D14 high: sample at fixed point, no wait
// - sampling hold-off over 1 us aborts conversion
// - bit-trial hold-off may stretch conversion time
// - D3 low filters bus pulses under 50 ns
// - D2:D1 selects none, busy or alert pin
// - writing 11 clears pin, flag, alert status
// - after clear, D2:D1 reads back 10
// - whole configuration register resets to zero
// - clear leaves pin enabled as alert output
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg_defs.svh"
module adc_config_alert_control
  import adc_cfg_pkg::*;
#(
  parameter int ALERT_W = 24,
  parameter int HOLD_CYC = `HOLD_CYC,
  parameter int FILT_CYC = `FILT_CYC
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // axi4-lite write address and data
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  // axi4-lite write response
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  output logic [1:0] AXI_BRESP_O,
  // axi4-lite read
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  input wire logic [7:0] AXI_ARADDR_I,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  // serial bus pins, observed only
  input wire logic SCL_I,
  input wire logic SDA_I,
  // converter core
  input wire logic CONV_START_I,
  input wire logic [ALERT_W-1:0] ALERT_EVENT_I,
  output logic SAMPLE_O,
  output logic BIT_TRIAL_O,
  output logic [3:0] TRIAL_BIT_O,
  output logic CONV_DONE_O,
  output logic CONV_ABORT_O,
  output logic CONV_BUSY_O,
  output logic [7:0] INPUT_MODE_O,
  output logic AUTOCYCLE_O,
  // alert flag and shared pin
  output logic ALERT_FLAG_O,
  output logic ALERT_BUSY_PIN_O,
  // interrupt
  output logic IRQ_O
);
  import adc_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int HW = $clog2(HOLD_CYC + 2);
  localparam logic [HW-1:0] HOLD_LIM = HW'(HOLD_CYC);
  localparam logic [3:0] TOP_BIT = 4'(`ADC_BITS - 1);

  logic [`CFG_W-1:0] cfg_q; // configuration register
  logic [`IRQ_W-1:0] irq_stat_q; // sticky interrupt events
  logic [`IRQ_W-1:0] irq_mask_q; // interrupt enables
  logic [ALERT_W-1:0] alert_q; // alert status bits
  logic alert_clr; // clear-alerts code seen this cycle
  logic aw_held_q; // write address latched
  logic w_held_q; // write data latched
  logic [7:0] waddr_q; // latched write address
  logic [31:0] wdata_q; // latched write data
  logic [3:0] wstrb_q; // latched byte enables
  logic do_wr; // both halves present, perform write
  logic bvalid_q; // write response pending
  logic [1:0] bresp_q; // write response code
  logic rvalid_q; // read data pending
  logic [31:0] rdata_q; // read data
  logic [1:0] rresp_q; // read response code
  logic scl_q; // previous filtered clock line
  logic sda_q; // previous filtered data line
  logic bus_act_q; // start seen, stop not yet
  conv_state_t st_q; // conversion sequencer state
  logic [HW-1:0] hold_q; // sampling hold-off length
  logic [3:0] bit_q; // bit under trial
  logic done_p; // conversion completed
  logic abort_p; // conversion aborted
  logic pin_q; // registered shared pin level
  logic [`IRQ_W-1:0] irq_ev; // interrupt events this cycle

  bus_filter_if fif ();

  // true when the address names a mapped register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_CONFIG) || (a == `OFS_IRQ_STAT) ||
             (a == `OFS_IRQ_MASK) || (a == `OFS_CORE_STAT) ||
             (a == `OFS_ALERT_STAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial line filter and bus activity

  assign fif.raw = {SCL_I, SDA_I};
  assign fif.bypass = cfg_q[`CFG_FILT_DIS];

  bus_glitch_filter #(.FILT_CYC(FILT_CYC)) i_bus_glitch_filter (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .f(fif.filt)
  );

  // bus counts as active from a start condition to a stop condition
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_q <= `LINE_IDLE;
      sda_q <= `LINE_IDLE;
      bus_act_q <= 1'b0;
    end else begin
      scl_q <= fif.clean[1];
      sda_q <= fif.clean[0];
      if (scl_q && fif.clean[1] && sda_q && !fif.clean[0]) begin
        bus_act_q <= 1'b1; // start
      end else if (scl_q && fif.clean[1] && !sda_q && fif.clean[0]) begin
        bus_act_q <= 1'b0; // stop
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  // address and data are accepted in either order, one write at a time
  assign AXI_AWREADY_O = !aw_held_q && !bvalid_q;
  assign AXI_WREADY_O = !w_held_q && !bvalid_q;
  assign do_wr = aw_held_q && w_held_q && !bvalid_q;

  // latch the two halves of a write
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (AXI_AWVALID_I && AXI_AWREADY_O) begin
        aw_held_q <= 1'b1;
        waddr_q <= AXI_AWADDR_I;
      end else if (do_wr) begin
        aw_held_q <= 1'b0;
      end
      if (AXI_WVALID_I && AXI_WREADY_O) begin
        w_held_q <= 1'b1;
        wdata_q <= AXI_WDATA_I;
        wstrb_q <= AXI_WSTRB_I;
      end else if (do_wr) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response, error for unmapped addresses
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (AXI_BREADY_I) begin
      bvalid_q <= 1'b0;
    end
  end

  assign AXI_BVALID_O = bvalid_q;
  assign AXI_BRESP_O = bresp_q;

  ////////////////////////////////////////////////////////////////////////
  // configuration register

  // clear-alerts code written into the low byte
  assign alert_clr = do_wr && waddr_q == `OFS_CONFIG && wstrb_q[0] &&
    wdata_q[`CFG_PIN_HI:`CFG_PIN_LO] == `PIN_CLEAR;

  // byte-lane writes; the clear code is never stored as such
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_q <= `CFG_RESET;
    end else if (do_wr && waddr_q == `OFS_CONFIG) begin
      if (wstrb_q[1]) begin
        cfg_q[15:8] <= wdata_q[15:8];
      end
      if (wstrb_q[0]) begin
        cfg_q[7:0] <= wdata_q[7:0];
        if (alert_clr) begin
          // read back 10 so the pin stays an alert output
          cfg_q[`CFG_PIN_HI:`CFG_PIN_LO] <= `PIN_ALERT;
        end
      end
    end
  end

  assign INPUT_MODE_O = cfg_q[`CFG_MODE_HI:`CFG_MODE_LO];
  assign AUTOCYCLE_O = cfg_q[`CFG_AUTOCYCLE];

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer with bus hold-off

  // sample waits on bus activity unless disabled; trials likewise.
  // an over-long sampling wait means the bus is misbehaving, so the
  // conversion is dropped instead of sampling late
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= CONV_IDLE;
      hold_q <= '0;
      bit_q <= 4'h0;
    end else begin
      unique case (st_q)
        CONV_IDLE: begin
          hold_q <= '0;
          // autocycle restarts the sequencer by itself
          if (CONV_START_I || cfg_q[`CFG_AUTOCYCLE]) begin
            st_q <= CONV_SAMPLE;
          end
        end
        CONV_SAMPLE: begin
          if (!cfg_q[`CFG_SMP_HOLD_DIS] && bus_act_q) begin
            if (hold_q == HOLD_LIM) begin
              st_q <= CONV_IDLE;
            end else begin
              hold_q <= hold_q + 1'b1;
            end
          end else begin
            st_q <= CONV_TRIAL; // fixed point when disabled
            bit_q <= TOP_BIT;
          end
        end
        CONV_TRIAL: begin
          if (!cfg_q[`CFG_TRIAL_HOLD_DIS] && bus_act_q) begin
            st_q <= CONV_TRIAL; // stall, conversion stretches
          end else if (bit_q == 4'h0) begin
            st_q <= CONV_IDLE;
          end else begin
            bit_q <= bit_q - 1'b1;
          end
        end
      endcase
    end
  end

  // strobes derived from the state
  always_comb begin
    SAMPLE_O = st_q == CONV_SAMPLE &&
      (cfg_q[`CFG_SMP_HOLD_DIS] || !bus_act_q);
    abort_p = st_q == CONV_SAMPLE && !SAMPLE_O &&
      hold_q == HOLD_LIM;
    BIT_TRIAL_O = st_q == CONV_TRIAL &&
      (cfg_q[`CFG_TRIAL_HOLD_DIS] || !bus_act_q);
    done_p = BIT_TRIAL_O && bit_q == 4'h0;
  end

  assign TRIAL_BIT_O = bit_q;
  assign CONV_DONE_O = done_p;
  assign CONV_ABORT_O = abort_p;
  assign CONV_BUSY_O = st_q != CONV_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // alert status and shared pin

  // events set, clear-alerts code or per-bit write-one clears; set wins
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      alert_q <= '0;
    end else if (alert_clr) begin
      alert_q <= ALERT_EVENT_I;
    end else if (do_wr && waddr_q == `OFS_ALERT_STAT) begin
      alert_q <= (alert_q & ~wdata_q[ALERT_W-1:0]) | ALERT_EVENT_I;
    end else begin
      alert_q <= alert_q | ALERT_EVENT_I;
    end
  end

  assign ALERT_FLAG_O = |alert_q;

  // pin function and polarity; the clear also drops the pin
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_q <= 1'b0;
    end else begin
      unique case (pin_mode_t'(cfg_q[`CFG_PIN_HI:`CFG_PIN_LO]))
        `PIN_BUSY: pin_q <= (st_q != CONV_IDLE) ~^ cfg_q[`CFG_POL];
        `PIN_ALERT: pin_q <= (|alert_q) ~^ cfg_q[`CFG_POL];
        default: pin_q <= !cfg_q[`CFG_POL]; // inactive level
      endcase
    end
  end

  assign ALERT_BUSY_PIN_O = pin_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  assign irq_ev = {|ALERT_EVENT_I, abort_p, done_p};

  // sticky bits, write one to clear, a new event beats the clear
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_stat_q <= '0;
    end else if (do_wr && waddr_q == `OFS_IRQ_STAT && wstrb_q[0]) begin
      irq_stat_q <= (irq_stat_q & ~wdata_q[`IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  // mask register, one enable per status bit
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_mask_q <= '0;
    end else if (do_wr && waddr_q == `OFS_IRQ_MASK && wstrb_q[0]) begin
      irq_mask_q <= wdata_q[`IRQ_W-1:0];
    end
  end

  assign IRQ_O = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign AXI_ARREADY_O = !rvalid_q;

  // one-cycle read, unmapped reads return zero with an error
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (AXI_ARVALID_I && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(AXI_ARADDR_I) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (AXI_ARADDR_I)
        `OFS_CONFIG: rdata_q <= 32'(cfg_q);
        `OFS_IRQ_STAT: rdata_q <= 32'(irq_stat_q);
        `OFS_IRQ_MASK: rdata_q <= 32'(irq_mask_q);
        `OFS_CORE_STAT: rdata_q <= 32'({bus_act_q, st_q != CONV_IDLE,
                                         |alert_q});
        `OFS_ALERT_STAT: rdata_q <= 32'(alert_q);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (AXI_RREADY_I) begin
      rvalid_q <= 1'b0;
    end
  end

  assign AXI_RVALID_O = rvalid_q;
  assign AXI_RDATA_O = rdata_q;
  assign AXI_RRESP_O = rresp_q;
endmodule
`default_nettype wire

// ===== logic/adc_cfg_defs.svh
// named constants for the converter configuration and alert block
// assumes a 100 MHz system clock and an AXI4-Lite register port
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH

// register byte offsets
`define OFS_CONFIG 8'h00
`define OFS_IRQ_STAT 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_CORE_STAT 8'h0C
`define OFS_ALERT_STAT 8'h10

// configuration register reset value and width
`define CFG_RESET 16'h0000
`define CFG_W 16

// configuration field positions
`define CFG_SMP_HOLD_DIS 14
`define CFG_TRIAL_HOLD_DIS 13
`define CFG_AUTOCYCLE 12
`define CFG_MODE_HI 11
`define CFG_MODE_LO 4
`define CFG_FILT_DIS 3
`define CFG_PIN_HI 2
`define CFG_PIN_LO 1
`define CFG_POL 0

// shared pin function codes
`define PIN_NONE 2'b00
`define PIN_BUSY 2'b01
`define PIN_ALERT 2'b10
`define PIN_CLEAR 2'b11

// interrupt status bit positions
`define IRQ_DONE 0
`define IRQ_ABORT 1
`define IRQ_ALERT 2
`define IRQ_W 3

// core status bit positions
`define CST_ALERT_FLAG 0
`define CST_CONV_BUSY 1
`define CST_BUS_ACTIVE 2

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// timing
`define CLK_MHZ 100
`define HOLD_NS 1000
`define FILT_NS 50
`define HOLD_CYC ((`HOLD_NS * `CLK_MHZ) / 1000)
`define FILT_CYC ((`FILT_NS * `CLK_MHZ + 999) / 1000)

// converter resolution and idle line level
`define ADC_BITS 12
`define LINE_IDLE 1'b1

`endif

// ===== logic/adc_cfg_pkg.sv
// types shared by the configuration and alert block
// assumes nothing beyond the defines header
`default_nettype none
package adc_cfg_pkg;
  // conversion sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_SAMPLE = 2'b01,
    CONV_TRIAL = 2'b10
  } conv_state_t;
  // shared pin function selection
  typedef logic [1:0] pin_mode_t;
endpackage
`default_nettype wire

// ===== logic/bus_filter_if.sv
// carrier between the control block and the serial line filter
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface bus_filter_if;
  logic [1:0] raw; // raw pins, bit 1 clock line, bit 0 data line
  logic [1:0] clean; // synchronised and filtered lines
  logic bypass; // filter bypass
  modport filt (input raw, input bypass, output clean);
  modport ctrl (output raw, output bypass, input clean);
endinterface
`default_nettype wire

// ===== logic/bus_glitch_filter.sv
// two-line glitch filter for the serial bus pins
// assumes raw pins are asynchronous; synchronises them first
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg_defs.svh"
module bus_glitch_filter #(
  parameter int FILT_CYC = `FILT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // lines
  bus_filter_if.filt f
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

  for (genvar g = 0; g < 2; g++) begin : g_line
    logic s1_q; // first sync stage, read only by s2_q
    logic s2_q; // second sync stage
    logic cl_q; // accepted line level
    logic [CW-1:0] cnt_q; // cycles the new level has persisted

    // two-stage synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1_q <= `LINE_IDLE;
        s2_q <= `LINE_IDLE;
      end else begin
        s1_q <= f.raw[g];
        s2_q <= s1_q;
      end
    end

    // a new level is taken only after it persisted the full window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cl_q <= `LINE_IDLE;
        cnt_q <= '0;
      end else if (s2_q == cl_q) begin
        cnt_q <= '0; // short pulse dies here
      end else if (f.bypass || cnt_q == LAST) begin
        cl_q <= s2_q; // bypass passes every edge
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end

    assign f.clean[g] = cl_q;
  end
endmodule
`default_nettype wire

// ===== verif/adc_cfg_checker_assertions.sv
// concurrent checks on the configuration and alert control block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module adc_cfg_checker #(
  parameter int ALERT_W = 24,
  parameter int HOLD_CYC = 100
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // watched ports
  input wire logic AXI_BVALID_O,
  input wire logic [ALERT_W-1:0] ALERT_EVENT_I,
  input wire logic SAMPLE_O,
  input wire logic BIT_TRIAL_O,
  input wire logic [3:0] TRIAL_BIT_O,
  input wire logic CONV_DONE_O,
  input wire logic CONV_ABORT_O,
  input wire logic CONV_BUSY_O,
  input wire logic [7:0] INPUT_MODE_O,
  input wire logic ALERT_FLAG_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////////
  logic trl_q; // sample taken, so waiting no longer counts
  logic [31:0] wait_q; // cycles spent waiting to sample
  // phase tracker, cleared whenever the converter goes idle
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trl_q <= 1'h0;
    end else if (!CONV_BUSY_O || CONV_DONE_O) begin
      trl_q <= 1'h0;
    end else if (SAMPLE_O) begin
      trl_q <= 1'h1;
    end
  end
  // wait counter, only in the sampling phase
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wait_q <= 32'h0;
    end else if (!CONV_BUSY_O || trl_q || SAMPLE_O || CONV_ABORT_O) begin
      // the abort cycle still shows busy, so it must stop the count too
      wait_q <= 32'h0;
    end else begin
      wait_q <= wait_q + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  property p_smp_next;
    SAMPLE_O |-> CONV_BUSY_O && !BIT_TRIAL_O ##1 TRIAL_BIT_O == 4'hB;
  endproperty
  a_smp_next: assert property (p_smp_next)
    else $error("sample not followed by top bit");
  property p_trial_step;
    BIT_TRIAL_O && TRIAL_BIT_O != 4'h0 |=>
      TRIAL_BIT_O == $past(TRIAL_BIT_O) - 4'h1;
  endproperty
  a_trial_step: assert property (p_trial_step)
    else $error("bit trials out of order");
  property p_done_last;
    CONV_DONE_O |-> BIT_TRIAL_O && TRIAL_BIT_O == 4'h0 ##1 !CONV_BUSY_O;
  endproperty
  a_done_last: assert property (p_done_last)
    else $error("done not on last trial");
  property p_abort_time;
    CONV_ABORT_O |-> !SAMPLE_O && !trl_q && wait_q == HOLD_CYC;
  endproperty
  a_abort_time: assert property (p_abort_time)
    else $error("abort at wrong wait count");
  property p_abort_idle;
    CONV_ABORT_O |=> !CONV_BUSY_O;
  endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("conversion kept running after abort");
  property p_wait_max;
    wait_q <= HOLD_CYC;
  endproperty
  a_wait_max: assert property (p_wait_max)
    else $error("sampling wait overran");
  property p_flag_set;
    |ALERT_EVENT_I |=> ALERT_FLAG_O;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("alert event lost");
  property p_flag_clr;
    $fell(ALERT_FLAG_O) |-> $rose(AXI_BVALID_O);
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("alert flag cleared without a write");
  property p_mode_hold;
    !$stable(INPUT_MODE_O) |-> $rose(AXI_BVALID_O);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode enables changed without a write");
  c_abort: cover property (CONV_ABORT_O);
  c_done: cover property (CONV_DONE_O);
  c_clear: cover property ($fell(ALERT_FLAG_O));
endmodule
bind adc_config_alert_control adc_cfg_checker #(
  .ALERT_W(ALERT_W),
  .HOLD_CYC(HOLD_CYC)
) i_adc_cfg_checker (
  .CLK_SYS_I(CLK_SYS_I),
  .RST_N_I(RST_N_I),
  .AXI_BVALID_O(AXI_BVALID_O),
  .ALERT_EVENT_I(ALERT_EVENT_I),
  .SAMPLE_O(SAMPLE_O),
  .BIT_TRIAL_O(BIT_TRIAL_O),
  .TRIAL_BIT_O(TRIAL_BIT_O),
  .CONV_DONE_O(CONV_DONE_O),
  .CONV_ABORT_O(CONV_ABORT_O),
  .CONV_BUSY_O(CONV_BUSY_O),
  .INPUT_MODE_O(INPUT_MODE_O),
  .ALERT_FLAG_O(ALERT_FLAG_O)
);
`default_nettype wire

// ===== verif/serial_master_model.sv
// model of the serial bus master sharing the two bus lines
// assumes pull-ups, so a released line reads high
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
  // paces the frames
  input wire logic clk_i,
  // bus lines after the pull-ups
  output logic scl_o,
  output logic sda_o
);
  // quiet unless the bench opens a frame; clock parks high
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // data falls under clock high, clock then parks low
  task automatic start_frame();
    @(posedge clk_i);
    sda_o <= 1'h0;
    repeat (5) @(posedge clk_i);
    scl_o <= 1'h0;
  endtask
  // data rises under clock high, which ends the frame
  task automatic stop_frame();
    @(posedge clk_i);
    sda_o <= 1'h0;
    scl_o <= 1'h1;
    repeat (5) @(posedge clk_i);
    sda_o <= 1'h1;
  endtask
  // 15 ns data dip that spans one edge under clock high
  task automatic glitch();
    @(posedge clk_i);
    #2 sda_o = 1'h0;
    #11 scl_o = 1'h0;
    #4 sda_o = 1'h1;
    #60 scl_o = 1'h1;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_adc_config_alert_control.sv
// self-checking bench for the configuration and alert control block
// assumes the serial master model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_adc_config_alert_control;
  localparam int HOLD = 4; // short hold-off keeps aborts quick
  logic clk = 1'h0, rst_n = 1'h0, st = 1'h0;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, de, r;
  logic [23:0] ev = 24'h0;
  logic awr, wrd, bv, arr, rv, smp, trl, dn, ab, bsy, auto, flg;
  logic pin, irq, scl, sda;
  logic [1:0] bresp, rresp, re;
  logic [3:0] tbit;
  logic [7:0] imode;
  logic [33:0] rq[$]; // read notes: resp, data
  logic [1:0] bq[$]; // write response notes
  int fail_count = 0, compares = 0, b, s, t, x, idx;
  integer seed = 32'hC2D2;
  always #5 clk = ~clk;
  adc_config_alert_control #(.HOLD_CYC(HOLD), .FILT_CYC(2))
    i_adc_config_alert_control (
    .CLK_SYS_I(clk), .RST_N_I(rst_n),
    .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa),
    .AXI_WVALID_I(wv), .AXI_WREADY_O(wrd), .AXI_WDATA_I(wd),
    .AXI_WSTRB_I(4'hF), .AXI_BVALID_O(bv), .AXI_BREADY_I(br),
    .AXI_BRESP_O(bresp), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
    .AXI_ARADDR_I(ara), .AXI_RVALID_O(rv), .AXI_RREADY_I(rr),
    .AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp), .SCL_I(scl), .SDA_I(sda),
    .CONV_START_I(st), .ALERT_EVENT_I(ev), .SAMPLE_O(smp),
    .BIT_TRIAL_O(trl), .TRIAL_BIT_O(tbit), .CONV_DONE_O(dn),
    .CONV_ABORT_O(ab), .CONV_BUSY_O(bsy), .INPUT_MODE_O(imode),
    .AUTOCYCLE_O(auto), .ALERT_FLAG_O(flg), .ALERT_BUSY_PIN_O(pin),
    .IRQ_O(irq));
  serial_master_model i_serial_master_model (
    .clk_i(clk), .scl_o(scl), .sda_o(sda));
  ////////////////////////////////////////////////////////////////////
  // compare and count; a mismatch is reported at once
  task automatic chk(input string n, input logic [31:0] sv, e);
    compares++;
    if (sv !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, sv);
    end
  endtask
  // register read; the expected answer goes on the queue
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] rs = 2'h0);
    rq.push_back({rs, e});
    @(posedge clk);
    arv <= 1'h1;
    ara <= a;
    rr <= 1'h1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'h0;
    do @(negedge clk); while (!rv);
    @(posedge clk);
    rr <= 1'h0;
  endtask
  // register write; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs = 2'h0);
    logic fa, fw, ha, hw;
    fa = 1'h0;
    fw = 1'h0;
    bq.push_back(rs);
    @(posedge clk);
    awv <= 1'h1;
    awa <= a;
    wv <= 1'h1;
    wd <= d;
    br <= 1'h1;
    while (!(fa && fw)) begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wrd;
      @(posedge clk);
      if (ha) awv <= 1'h0;
      if (hw) wv <= 1'h0;
      fa = fa || ha;
      fw = fw || hw;
    end
    do @(negedge clk); while (!bv);
    @(posedge clk);
    br <= 1'h0;
  endtask
  // one conversion: busy cycles, samples, trials, aborts
  task automatic conv(output int bc, sc, tc, xc);
    bc = 0;
    sc = 0;
    tc = 0;
    xc = 0;
    @(posedge clk);
    st <= 1'h1;
    @(posedge clk);
    st <= 1'h0;
    do begin
      @(negedge clk);
      bc += bsy;
      sc += smp;
      tc += trl;
      xc += ab;
    end while (!dn && !ab && bc < 300);
  endtask
  // pin is registered: let two cycles pass before looking
  task automatic pc(input logic e);
    repeat (2) @(negedge clk);
    chk("pin", pin, e);
  endtask
  // one alert event on a random line
  task automatic evt();
    @(posedge clk);
    ev <= 24'h1 << idx;
    @(posedge clk);
    ev <= 24'h0;
  endtask
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // watcher: oldest note against each response that crosses
  always @(negedge clk) begin
    if (rv && rr) begin
      {re, de} = rq.pop_front();
      chk("rdata", rdat, de);
      chk("rresp", {30'h0, rresp}, {30'h0, re});
    end
    if (bv && br) begin
      re = bq.pop_front();
      chk("bresp", {30'h0, bresp}, {30'h0, re});
    end
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    pc(1'h1);
    $display("test reset done");
    conv(b, s, t, x);
    chk("busy", b, 13);
    chk("trials", t, 12);
    wr(8'h08, 32'h7);
    rd(8'h04, 32'h1);
    chk("irq", irq, 1);
    wr(8'h04, 32'h1);
    chk("irq", irq, 0);
    i_serial_master_model.start_frame();
    repeat (8) @(posedge clk);
    rd(8'h0C, 32'h4);
    conv(b, s, t, x);
    chk("abort", x, 1);
    chk("sampled", s, 0);
    chk("wait", b, HOLD + 1);
    rd(8'h04, 32'h2);
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h6000);
    conv(b, s, t, x);
    chk("fixed", b, 13);
    wr(8'h00, 32'h4000);
    fork
      conv(b, s, t, x);
      begin
        repeat (20) @(posedge clk);
        i_serial_master_model.stop_frame();
      end
    join
    chk("stretch", b > 13, 1);
    chk("trials", t, 12);
    $display("test hold-off done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, k ? 32'h8 : 32'h0);
      repeat (10) @(posedge clk);
      i_serial_master_model.glitch();
      repeat (10) @(posedge clk);
      rd(8'h0C, k ? 32'h4 : 32'h0);
      i_serial_master_model.stop_frame();
    end
    $display("test filter done");
    idx = {$random(seed)} % 24;
    wr(8'h00, 32'h4);
    evt();
    pc(1'h0);
    rd(8'h10, 32'h1 << idx);
    wr(8'h00, 32'h6);
    pc(1'h1);
    chk("flag", flg, 0);
    rd(8'h00, 32'h4);
    rd(8'h10, 32'h0);
    evt();
    pc(1'h0);
    wr(8'h00, 32'h5);
    pc(1'h1);
    wr(8'h00, 32'h1);
    pc(1'h0);
    wr(8'h00, 32'h3);
    fork
      conv(b, s, t, x);
      begin
        repeat (3) @(posedge clk); // pin trails busy by one edge
        pc(1'h1);
      end
    join
    pc(1'h0);
    $display("test pin done");
    r = $random(seed) & 32'hFF0;
    wr(8'h00, r);
    chk("mode", imode, r[11:4]);
    rd(8'h00, r);
    wr(8'h00, 32'h1000);
    repeat (3) @(negedge clk);
    chk("auto", {auto, bsy}, 2'h3);
    wr(8'h00, 32'h0);
    repeat (20) @(negedge clk);
    chk("auto", {auto, bsy}, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    $display("test modes done");
    end_of_test();
  end
endmodule
`default_nettype wire
